// File: design/hss_cfg.svh
// Purpose: Constants for the axis home search sequencer
// Assumes: Feedback counts are micrometres of travel
// Notes:   Included by the sequencer module only
`ifndef HSS_CFG_SVH
`define HSS_CFG_SVH

// --------------------------------------------------------------
// Distance-coded search travel limits, millimetres and micrometres
// --------------------------------------------------------------
`define HSS_LIMIT_SHORT_MM    20
`define HSS_LIMIT_LONG_MM     100
`define HSS_UM_PER_MM         1000
`define HSS_LIMIT_SHORT_UM    (`HSS_LIMIT_SHORT_MM * `HSS_UM_PER_MM)
`define HSS_LIMIT_LONG_UM     (`HSS_LIMIT_LONG_MM * `HSS_UM_PER_MM)

// --------------------------------------------------------------
// Marker search type codes
// --------------------------------------------------------------
`define HSS_MST_WIDTH         2
`define HSS_MST_RELEASE       2'h3

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define HSS_RST_TRAVEL        32'h0

`endif

// File: design/hss_pkg.sv
// Purpose: Types shared by the axis home search sequencer
// Assumes: Nothing beyond the constants header
// Notes:   State codes are one-hot
package hss_pkg;

   // --------------------------------------------------------------
   // Sequencer states
   // --------------------------------------------------------------
   typedef enum logic [7:0] {
      HSS_IDLE     = 8'h01,
      HSS_APPROACH = 8'h02,
      HSS_PICK     = 8'h04,
      HSS_RELEASE  = 8'h08,
      HSS_MARKER   = 8'h10,
      HSS_SHIFT    = 8'h20,
      HSS_LOAD     = 8'h40,
      HSS_FAIL     = 8'h80
   } hss_state_e;

endpackage : hss_pkg

// File: design/hss_axis_home_search_sequencer.sv
// Purpose: Homes a group of axes, driving run/direction/feed commands
// Assumes: Inputs synchronous to clk; axis_step pulses once per um moved
// Notes:   Selected order is ascending axis index
// Operation
// - A homing request comes from jog or a program and may select one or several axes.
// - A jog request cancels the active zero offset and each homed axis shows its reference coordinate.
// - A program request keeps the active part zero and positions stay relative to it.
// - Incremental axes with a switch first move together in their search direction at approach feedrate until their switch.
// - Once all switches are reached, axes search the marker one at a time in order at homing feedrate.
// - With marker search type 3, each axis in order backs off at homing feedrate until its switch releases.
// - After release the first marker met is home, with direction and feedrate unchanged.
// - Distance-coded axes need no switch and are homed strictly one at a time in order.
// - A distance-coded search moves in search direction at homing feedrate no farther than 20 mm or 100 mm.
// - A switch pressed during a distance-coded search reverses that axis's direction.
// - After the marker the axis moves on by its marker shift distance at homing feedrate.
// - Plain incremental axes are synchronized at the marker location.
`include "hss_cfg.svh"

module hss_axis_home_search_sequencer
   import hss_pkg::*;
#(
   parameter int NAX = 4,
   parameter int FW  = 16,
   parameter int CW  = 32
) (
   input  wire logic                                clk,
   input  wire logic                                sys_rst,
   input  wire logic                                ce,
   input  wire logic                                home_request,
   input  wire logic                                request_from_program,
   input  wire logic [NAX-1:0]                      axis_select,
   input  wire logic [NAX-1:0]                      search_direction,
   input  wire logic [NAX-1:0]                      has_home_switch,
   input  wire logic [NAX-1:0]                      distance_coded,
   input  wire logic [NAX-1:0]                      coded_long_range,
   input  wire logic [NAX*`HSS_MST_WIDTH-1:0]       marker_search_type,
   input  wire logic [NAX*FW-1:0]                   approach_feedrate,
   input  wire logic [NAX*FW-1:0]                   homing_feedrate,
   input  wire logic [NAX*CW-1:0]                   marker_shift_distance,
   input  wire logic [NAX*CW-1:0]                   reference_coordinate,
   input  wire logic [NAX-1:0]                      home_switch,
   input  wire logic [NAX-1:0]                      marker_pulse,
   input  wire logic [NAX-1:0]                      axis_step,
   output logic      [NAX-1:0]                      axis_run,
   output logic      [NAX-1:0]                      axis_dir,
   output logic      [NAX*FW-1:0]                   axis_feed,
   output logic                                     pos_load,
   output logic      [$clog2(NAX)-1:0]              pos_load_axis,
   output logic      [CW-1:0]                       pos_load_value,
   output logic                                     zero_offset_cancel,
   output logic                                     keep_part_zero,
   output logic      [NAX-1:0]                      axis_homed,
   output logic                                     busy,
   output logic                                     search_done,
   output logic                                     search_fail
);

   localparam int AW = $clog2(NAX);
   localparam logic [31:0] LIM_SHORT = 32'(`HSS_LIMIT_SHORT_UM);
   localparam logic [31:0] LIM_LONG  = 32'(`HSS_LIMIT_LONG_UM);

   // --------------------------------------------------------------
   // Lowest pending axis in a mask
   // --------------------------------------------------------------
   function automatic logic [AW-1:0] first_axis(input logic [NAX-1:0] mask);
      logic [AW-1:0] idx;
      idx = '0;
      for (int k = NAX - 1; k >= 0; k--) begin
         if (mask[k]) begin
            idx = AW'(k);
         end
      end
      return idx;
   endfunction : first_axis

   hss_state_e        state;
   logic [AW-1:0]     cur;
   logic [NAX-1:0]    sel;
   logic [NAX-1:0]    appr;
   logic [NAX-1:0]    finished;
   logic              from_prog;
   logic              rev;
   logic              sw_prev;
   logic [31:0]       travel;

   logic [NAX-1:0]    pending;
   logic [AW-1:0]     next_axis;
   logic              cur_sw;
   logic              cur_step;
   logic [31:0]       cur_shift;
   logic [31:0]       cur_limit;

   assign pending     = sel & ~finished;
   assign next_axis   = first_axis(pending);
   assign cur_sw      = home_switch[cur];
   assign cur_step    = axis_step[cur];
   assign cur_shift   = 32'(marker_shift_distance[cur*CW +: CW]);
   assign cur_limit   = coded_long_range[cur] ? LIM_LONG : LIM_SHORT;

   // --------------------------------------------------------------
   // Sequence control
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state     <= HSS_IDLE;
         cur       <= '0;
         sel       <= '0;
         appr      <= '0;
         finished  <= '0;
         from_prog <= 1'b0;
         rev       <= 1'b0;
         sw_prev   <= 1'b0;
         travel    <= `HSS_RST_TRAVEL;
      end else if (ce) begin
         sw_prev <= cur_sw;
         unique case (state)
            HSS_IDLE: begin
               if (home_request && (|axis_select)) begin
                  sel       <= axis_select;
                  from_prog <= request_from_program;
                  finished  <= '0;
                  // Axes without a switch or with coded scales sit out the approach
                  appr      <= axis_select & has_home_switch & ~distance_coded;
                  state     <= HSS_APPROACH;
               end
            end
            HSS_APPROACH: begin
               appr <= appr & ~home_switch;
               if ((appr & ~home_switch) == '0) begin
                  state <= HSS_PICK;
               end
            end
            HSS_PICK: begin
               travel <= `HSS_RST_TRAVEL;
               rev    <= 1'b0;
               cur    <= next_axis;
               // Edge detect restarts on the new axis, not on the old one's switch
               sw_prev <= home_switch[next_axis];
               if (pending == '0) begin
                  state <= HSS_IDLE;
               end else if (!distance_coded[next_axis] &&
                            (marker_search_type[next_axis*`HSS_MST_WIDTH +: `HSS_MST_WIDTH] == `HSS_MST_RELEASE)
                            && has_home_switch[next_axis]) begin
                  rev   <= 1'b1;
                  state <= HSS_RELEASE;
               end else begin
                  state <= HSS_MARKER;
               end
            end
            HSS_RELEASE: begin
               // Direction stays reversed into the marker search
               if (!cur_sw) begin
                  state <= HSS_MARKER;
               end
            end
            HSS_MARKER: begin
               if (marker_pulse[cur]) begin
                  travel <= `HSS_RST_TRAVEL;
                  state  <= (cur_shift != 32'h0) ? HSS_SHIFT : HSS_LOAD;
               end else if (distance_coded[cur]) begin
                  if (cur_step) begin
                     travel <= travel + 32'h1;
                  end
                  if (travel >= cur_limit) begin
                     state <= HSS_FAIL;
                  end
                  if (cur_sw && !sw_prev && has_home_switch[cur]) begin
                     rev <= ~rev;
                  end
               end
            end
            HSS_SHIFT: begin
               if (cur_step) begin
                  travel <= travel + 32'h1;
               end
               // Count the step landing now, else the stop order comes a cycle late
               if ((travel + 32'(cur_step)) >= cur_shift) begin
                  state <= HSS_LOAD;
               end
            end
            HSS_LOAD: begin
               finished[cur] <= 1'b1;
               state         <= HSS_PICK;
            end
            HSS_FAIL: begin
               // Abandons the whole request; already homed axes keep their flag
               state <= HSS_IDLE;
            end
         endcase
      end
   end

   // --------------------------------------------------------------
   // Per-axis motion commands
   // --------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NAX; gi++) begin : g_axis
         logic active;
         assign active = (cur == AW'(gi)) &&
                         (state inside {HSS_RELEASE, HSS_MARKER, HSS_SHIFT});
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               axis_run[gi]              <= 1'b0;
               axis_dir[gi]              <= 1'b0;
               axis_feed[gi*FW +: FW]    <= '0;
            end else if (ce) begin
               if (state == HSS_APPROACH && appr[gi] && !home_switch[gi]) begin
                  axis_run[gi]           <= 1'b1;
                  axis_dir[gi]           <= search_direction[gi];
                  axis_feed[gi*FW +: FW] <= approach_feedrate[gi*FW +: FW];
               end else if (active) begin
                  axis_run[gi]           <= 1'b1;
                  axis_dir[gi]           <= search_direction[gi] ^ rev;
                  axis_feed[gi*FW +: FW] <= homing_feedrate[gi*FW +: FW];
               end else begin
                  axis_run[gi]           <= 1'b0;
                  axis_dir[gi]           <= search_direction[gi];
                  axis_feed[gi*FW +: FW] <= '0;
               end
            end
         end
      end
   endgenerate

   // --------------------------------------------------------------
   // Coordinate load and status
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pos_load           <= 1'b0;
         pos_load_axis      <= '0;
         pos_load_value     <= '0;
         zero_offset_cancel <= 1'b0;
         keep_part_zero     <= 1'b0;
         axis_homed         <= '0;
         search_done        <= 1'b0;
         search_fail        <= 1'b0;
      end else if (ce) begin
         pos_load           <= 1'b0;
         zero_offset_cancel <= 1'b0;
         search_done        <= 1'b0;
         search_fail        <= 1'b0;
         if (state == HSS_IDLE && home_request && (|axis_select)) begin
            axis_homed     <= axis_homed & ~axis_select;
            keep_part_zero <= request_from_program;
         end
         if (state == HSS_LOAD) begin
            pos_load           <= 1'b1;
            pos_load_axis      <= cur;
            pos_load_value     <= reference_coordinate[cur*CW +: CW];
            zero_offset_cancel <= ~from_prog;
            axis_homed[cur]    <= 1'b1;
         end
         if (state == HSS_PICK && pending == '0) begin
            search_done <= 1'b1;
         end
         if (state == HSS_FAIL) begin
            search_fail <= 1'b1;
         end
      end
   end

   assign busy = (state != HSS_IDLE);

endmodule : hss_axis_home_search_sequencer

// File: verification/hss_axis_model.sv
// Purpose: Behavioural axes with home switch, marker and step feedback
// Assumes: One um of travel per clk while an axis runs
// Notes:   Switch pressed over 40..45 um, markers every 16 um
module hss_axis_model #(parameter int NAX = 2) (
   input  wire logic           clk,
   input  wire logic           place,
   input  wire logic [31:0]    place_pos,
   input  wire logic           mk_en,
   input  wire logic [NAX-1:0] axis_run,
   input  wire logic [NAX-1:0] axis_dir,
   output logic      [NAX-1:0] home_switch,
   output logic      [NAX-1:0] marker_pulse,
   output logic      [NAX-1:0] axis_step,
   output int                  pos [NAX]
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk) begin
      for (int i = 0; i < NAX; i++) begin
         axis_step[i] <= axis_run[i] && !place;
         if (place) begin
            pos[i] <= int'(place_pos);
         end else if (axis_run[i]) begin
            pos[i] <= axis_dir[i] ? pos[i] + 1 : pos[i] - 1;
         end
      end
   end
   // Narrow switch band so plain markers are met with the switch free
   always_comb begin
      for (int i = 0; i < NAX; i++) begin
         home_switch[i] = pos[i] >= 40 && pos[i] <= 45;
         marker_pulse[i] = mk_en && pos[i] > 0 && pos[i] % 16 == 0;
      end
   end
endmodule : hss_axis_model

// File: verification/hss_properties.sv
// Purpose: Port assertions for the home search sequencer
// Assumes: One clock, synchronous reset
// Notes:   Travel bound checked for the short coded range only
module hss_checker #(parameter int NAX = 2, parameter int FW = 16, parameter int CW = 32) (
   input wire logic                   clk,
   input wire logic                   sys_rst,
   input wire logic                   ce,
   input wire logic                   home_request,
   input wire logic [NAX-1:0]         axis_select,
   input wire logic [NAX-1:0]         search_direction,
   input wire logic [NAX-1:0]         has_home_switch,
   input wire logic [NAX-1:0]         distance_coded,
   input wire logic [NAX-1:0]         coded_long_range,
   input wire logic [NAX*FW-1:0]      approach_feedrate,
   input wire logic [NAX*FW-1:0]      homing_feedrate,
   input wire logic [NAX*CW-1:0]      marker_shift_distance,
   input wire logic [NAX*CW-1:0]      reference_coordinate,
   input wire logic [NAX-1:0]         home_switch,
   input wire logic [NAX-1:0]         marker_pulse,
   input wire logic [NAX-1:0]         axis_step,
   input wire logic [NAX-1:0]         axis_run,
   input wire logic [NAX-1:0]         axis_dir,
   input wire logic [NAX*FW-1:0]      axis_feed,
   input wire logic                   pos_load,
   input wire logic [$clog2(NAX)-1:0] pos_load_axis,
   input wire logic [CW-1:0]          pos_load_value,
   input wire logic                   zero_offset_cancel,
   input wire logic                   keep_part_zero,
   input wire logic [NAX-1:0]         axis_homed,
   input wire logic                   busy,
   input wire logic                   search_done,
   input wire logic                   search_fail
);
   int steps;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Steps of the running request; a few may land after the stop order
   always_ff @(posedge clk) begin
      if (sys_rst || !busy) begin
         steps <= 0;
      end else if (|axis_step) begin
         steps <= steps + 1;
      end
   end
   sequence s_take;
      ce && !busy && home_request && (|axis_select);
   endsequence
   chk_take_busy: assert property (s_take |=> busy) else $error("request not taken");
   chk_jog_cancel: assert property (pos_load && !keep_part_zero |-> zero_offset_cancel)
      else $error("jog load without offset cancel");
   chk_prog_keep: assert property (zero_offset_cancel |-> pos_load && !keep_part_zero)
      else $error("offset cancelled on program request");
   chk_load_value: assert property (pos_load |-> pos_load_value == reference_coordinate[pos_load_axis*CW +: CW]
      ##[0:1] axis_homed[pos_load_axis]) else $error("load value or homed flag wrong");
   chk_done_idle: assert property (search_done |-> !busy ##1 !search_done)
      else $error("done not a single pulse");
   chk_fail_limit: assert property (search_fail && !(|coded_long_range) |-> steps inside {[20000:20006]})
      else $error("coded limit not at short range");
   for (genvar i = 0; i < NAX; i++) begin : g_ax
      wire logic [FW-1:0] feed = axis_feed[i*FW +: FW];
      sequence s_marker_hit;
         axis_run[i] && marker_pulse[i] && !home_switch[i] && feed == homing_feedrate[i*FW +: FW]
            && marker_shift_distance[i*CW +: CW] == '0;
      endsequence
      chk_stop_feed: assert property (!axis_run[i] |-> feed == '0) else $error("feed while stopped");
      chk_group_feed: assert property (axis_run[i] && $countones(axis_run) > 1 |->
         feed == approach_feedrate[i*FW +: FW]) else $error("group move not at approach feed");
      chk_single_homing: assert property (axis_run[i] && feed == homing_feedrate[i*FW +: FW] |->
         $countones(axis_run) == 1) else $error("two axes at homing feed");
      chk_marker_stop: assert property (s_marker_hit |-> ##[1:3] !axis_run[i])
         else $error("axis ran past marker");
      chk_coded_reverse: assert property (distance_coded[i] && has_home_switch[i] && axis_run[i]
         && $rose(home_switch[i]) |-> ##[1:3] axis_dir[i] != search_direction[i]) else $error("no reversal");
   end
endmodule : hss_checker

bind hss_axis_home_search_sequencer hss_checker #(.NAX(NAX), .FW(FW), .CW(CW)) hss_checker_i (
   .clk, .sys_rst, .ce, .home_request, .axis_select, .search_direction, .has_home_switch, .distance_coded,
   .coded_long_range, .approach_feedrate, .homing_feedrate, .marker_shift_distance, .reference_coordinate,
   .home_switch, .marker_pulse, .axis_step, .axis_run, .axis_dir, .axis_feed, .pos_load, .pos_load_axis,
   .pos_load_value, .zero_offset_cancel, .keep_part_zero, .axis_homed, .busy, .search_done, .search_fail);

// File: verification/test_axis_home_search_sequencer.sv
// Purpose: Self-checking bench for the home search sequencer
// Assumes: Two axes, search direction positive, inputs set at falling edge
// Notes:   Coded failure run walks the full 20 mm limit
module test_axis_home_search_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, sys_rst, ce, home_request, request_from_program, place, mk_en;
   logic [1:0]  axis_select, search_direction, has_home_switch, distance_coded, coded_long_range;
   logic [3:0]  marker_search_type;
   logic [31:0] approach_feedrate, homing_feedrate, place_pos, axis_feed, pos_load_value;
   logic [63:0] marker_shift_distance, reference_coordinate;
   logic [1:0]  home_switch, marker_pulse, axis_step, axis_run, axis_dir, axis_homed;
   logic        pos_load, pos_load_axis, zero_offset_cancel, keep_part_zero, busy, search_done, search_fail;
   int          pos [2];
   int          errors, num_checks, cycles;
   hss_axis_home_search_sequencer #(.NAX(2), .FW(16), .CW(32)) hss_axis_home_search_sequencer_i (
      .clk, .sys_rst, .ce, .home_request, .request_from_program, .axis_select, .search_direction,
      .has_home_switch, .distance_coded, .coded_long_range, .marker_search_type, .approach_feedrate,
      .homing_feedrate, .marker_shift_distance, .reference_coordinate, .home_switch, .marker_pulse,
      .axis_step, .axis_run, .axis_dir, .axis_feed, .pos_load, .pos_load_axis, .pos_load_value,
      .zero_offset_cancel, .keep_part_zero, .axis_homed, .busy, .search_done, .search_fail);
   hss_axis_model #(.NAX(2)) hss_axis_model_i (.clk, .place, .place_pos, .mk_en, .axis_run, .axis_dir,
      .home_switch, .marker_pulse, .axis_step, .pos);
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (exp !== got) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   task automatic setup(logic [1:0] sw, logic [1:0] cd, logic [3:0] ty, logic [63:0] sh, int p);
      has_home_switch = sw;
      distance_coded = cd;
      marker_search_type = ty;
      marker_shift_distance = sh;
      place_pos = p;
      place = 1'b1;
      @(negedge clk);
      place = 1'b0;
   endtask : setup
   task automatic start(logic [1:0] sel, logic prog);
      axis_select = sel;
      request_from_program = prog;
      home_request = 1'b1;
      @(negedge clk);
      home_request = 1'b0;
   endtask : start
   // Sign gives travel direction so overshoot after the stop order is allowed
   task automatic wait_load(logic ax, int exp_pos, int sgn);
      int n;
      n = 0;
      while (pos_load !== 1'b1 && n < 30000) begin
         @(negedge clk);
         n++;
      end
      check("load pulse", 1'b1, pos_load);
      check("load axis", ax, pos_load_axis);
      check("load value", reference_coordinate[ax*32 +: 32], pos_load_value);
      check("offset cancel", !request_from_program, zero_offset_cancel);
      check("travel", 1, (pos[ax] - exp_pos) * sgn inside {[0:2]});
      @(negedge clk);
   endtask : wait_load
   task automatic finish_req(logic [1:0] homed, logic fail);
      int n;
      n = 0;
      while (search_done !== 1'b1 && search_fail !== 1'b1 && n < 30000) begin
         @(negedge clk);
         n++;
      end
      check("outcome", {!fail, fail}, {search_done, search_fail});
      check("homed", homed, axis_homed);
      check("part zero kept", request_from_program, keep_part_zero);
      @(negedge clk);
      check("idle", 1'b0, busy);
   endtask : finish_req
   task automatic t_jog_plain();
      setup(2'b11, 2'b00, 4'h0, 64'h0, 5);
      start(2'b11, 1'b0);
      repeat (3) @(negedge clk);
      check("group run", 2'b11, axis_run);
      check("group feed", approach_feedrate, axis_feed);
      // Enable low holds the commands while the axes keep rolling
      ce = 1'b0;
      repeat (2) @(negedge clk);
      check("frozen run", 2'b11, axis_run);
      ce = 1'b1;
      wait_load(1'b0, 48, 1);
      wait_load(1'b1, 48, 1);
      finish_req(2'b11, 1'b0);
   endtask : t_jog_plain
   task automatic t_prog_release();
      setup(2'b01, 2'b00, 4'hf, {32'h0, 32'h5}, 5);
      start(2'b11, 1'b1);
      repeat (3) @(negedge clk);
      check("solo approach", {16'h0, approach_feedrate[15:0]}, axis_feed);
      wait_load(1'b0, 27, -1);
      wait_load(1'b1, 16, 1);
      finish_req(2'b11, 1'b0);
   endtask : t_prog_release
   task automatic t_coded_reverse();
      reference_coordinate = {32'h0000_2000, 32'h0000_3000};
      setup(2'b01, 2'b01, 4'h0, 64'h0, 38);
      start(2'b01, 1'b0);
      repeat (5) @(negedge clk);
      check("coded feed", {16'h0, homing_feedrate[15:0]}, axis_feed);
      wait_load(1'b0, 32, -1);
      finish_req(2'b11, 1'b0);
   endtask : t_coded_reverse
   task automatic t_coded_fail();
      mk_en = 1'b0;
      setup(2'b00, 2'b01, 4'h0, 64'h0, 5);
      start(2'b01, 1'b0);
      finish_req(2'b10, 1'b1);
      check("coded travel", 1, pos[0] - 5 inside {[20000:20004]});
      mk_en = 1'b1;
   endtask : t_coded_fail
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {sys_rst, ce, mk_en} = 3'h7;
      {home_request, request_from_program, place, axis_select} = 5'h0;
      {search_direction, coded_long_range} = 4'hc;
      {has_home_switch, distance_coded, marker_search_type} = 8'h0;
      {approach_feedrate, homing_feedrate} = {32'h0022_0011, 32'h0004_0003};
      {place_pos, marker_shift_distance} = 96'h0;
      reference_coordinate = {32'h0000_2000, 32'h0000_1000};
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      check("reset outputs", 32'h0, {axis_run, axis_homed, busy, pos_load, search_done});
      t_jog_plain();
      t_prog_release();
      t_coded_reverse();
      t_coded_fail();
      conclude();
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         conclude();
      end
   end
endmodule : test_axis_home_search_sequencer
